// ===== rtl/gdc_pkg.sv
// Operation
// RULE1: Bit 10 of the protection word picks the overcurrent trip level, 0 for 9 A and 1 for 13 A.
// RULE2: Bits 9-8 of the protection word pick the overcurrent fault response, 0 latched, 1 auto-retry after 500 ms, 2 and 3 reserved, reset value 1.
// RULE3: Bits 1-0 of the protection word pick the sense gain 0.24/0.48/0.96/1.92 V/A, used only while automatic gain is off.
// RULE4: Bit 30 of the second word enables driver delay compensation.
// RULE5: Bits 29-26 of the second word pick the delay target, 0 automatic, 1..15 from 0.4 us to 3.2 us in 0.2 us steps.
// RULE6: Bit 24 disables regulator sequencing, resets to 1, and a written one clears it.
// RULE7: Bit 23 picks the regulator current limit, 0 for 600 mA and 1 for 150 mA.
// RULE8: Bits 22-21 pick the regulator output voltage 3.3/5.0/4.0/5.7 V, reset value 1.
// RULE9: Bit 20 turns the regulator off when 1 and resets to 0.
// RULE10: Bits 19-17 pick the low-side minimum on-time, 0 none, 1 automatic, 2..7 from 0.5 us to 2 us.
// RULE11: The second word sits at offset AEh, resets to 01200000h, and its bits 16-0 and 25 read zero.
// RULE12: Writes to reserved bits are ignored and those bits always read zero.
package gdc_pkg;
    localparam logic [7:0]  GDC_PROT_OFS       = 8'hAC;
    localparam logic [7:0]  GDC_BUCK_OFS       = 8'hAE;
    localparam logic [31:0] GDC_PROT_RST       = 32'h10228100;
    localparam logic [31:0] GDC_BUCK_RST       = 32'h01200000;
    // Writable bits of each word; everything else is reserved
    localparam logic [31:0] GDC_PROT_WMASK     = 32'h8C0C3703;
    localparam logic [31:0] GDC_BUCK_WMASK     = 32'hFDFE0000;
    // Write-one-to-clear bits of the second word
    localparam logic [31:0] GDC_BUCK_W1C       = 32'h01000000;
    localparam int          GDC_TRIP_LEVEL_BIT = 10;
    localparam int          GDC_FAULT_RESP_LSB = 8;
    localparam int          GDC_GAIN_LSB       = 0;
    localparam int          GDC_DCOMP_EN_BIT   = 30;
    localparam int          GDC_TDELAY_LSB     = 26;
    localparam int          GDC_SEQ_DIS_BIT    = 24;
    localparam int          GDC_CL_BIT         = 23;
    localparam int          GDC_VSEL_LSB       = 21;
    localparam int          GDC_DIS_BIT        = 20;
    localparam int          GDC_MINON_LSB      = 17;
endpackage

// ===== rtl/gdc_word_if.sv
`timescale 1ns/10ps
`default_nettype none
// Write request carried into one register word
interface gdc_word_if;
    logic        we;
    logic [31:0] wdata;
    logic [31:0] q;
    modport ctl (output we, output wdata, input q);
    modport reg_side (input we, input wdata, output q);
endinterface
`default_nettype wire

// ===== rtl/gdc_word.sv
`timescale 1ns/10ps
`default_nettype none
// One stored configuration word with reserved and write-one-clear masks
module gdc_word
    import gdc_pkg::*;
#(
    parameter logic [31:0] RST   = 32'h00000000,
    parameter logic [31:0] WMASK = 32'hFFFFFFFF,
    parameter logic [31:0] W1C   = 32'h00000000
) (
    input  wire logic clk_i,   // Clock
    input  wire logic srst_i,  // Sync reset
    gdc_word_if.reg_side w     // Word access
);
    logic [31:0] word_r;
    logic [31:0] word_nxt;

    // Plain bits take data, W1C bits only fall on a written one
    always_comb begin
        word_nxt = word_r;
        if (w.we) begin
            word_nxt = ((w.wdata & WMASK & ~W1C) | (word_r & ~WMASK)) & WMASK; // RULE12
            word_nxt = word_nxt | (word_r & W1C & ~w.wdata);                   // RULE6
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            word_r <= RST & WMASK;  // RULE11
        end else begin
            word_r <= word_nxt;
        end
    end

    assign w.q = word_r;

    a_reserved_zero: assert property (@(posedge clk_i) disable iff (srst_i) // RULE12
        (word_r & ~WMASK) == 32'h00000000) else $error("reserved bit set");
endmodule
`default_nettype wire

// ===== rtl/gdc_regs.sv
`timescale 1ns/10ps
`default_nettype none
// Gate driver configuration register bank: two stored words and decoded controls
module gdc_regs
    import gdc_pkg::*;
(
    input  wire logic        clk_i,              // 200 MHz clock
    input  wire logic        srst_i,             // Sync reset, high
    input  wire logic        wr_en_i,            // Write strobe
    input  wire logic        rd_en_i,            // Read strobe
    input  wire logic [7:0]  addr_i,             // Register offset
    input  wire logic [31:0] wdata_i,            // Write data
    input  wire logic        auto_gain_en_i,     // Automatic sense gain active
    output logic      [31:0] rdata_o,            // Registered read data
    output logic             rvalid_o,           // Read data valid pulse
    output logic             ocp_level_o,        // Trip level select
    output logic      [1:0]  ocp_response_o,     // Fault response
    output logic      [1:0]  sense_gain_o,       // Programmed static gain code
    output logic             sense_gain_use_o,   // Static gain in force
    output logic             dcomp_en_o,         // Delay compensation on
    output logic      [3:0]  target_delay_o,     // Delay target code
    output logic             seq_disable_o,      // Regulator sequencing off
    output logic             reg_cl_sel_o,       // Regulator current limit
    output logic      [1:0]  reg_vsel_o,         // Regulator voltage code
    output logic             reg_disable_o,      // Regulator off
    output logic      [2:0]  min_on_time_o       // Low-side minimum on code
);
    gdc_word_if prot_w ();
    gdc_word_if buck_w ();

    // Offset decode for writes
    assign prot_w.we    = wr_en_i && (addr_i == GDC_PROT_OFS);
    assign prot_w.wdata = wdata_i;
    assign buck_w.we    = wr_en_i && (addr_i == GDC_BUCK_OFS);  // RULE11
    assign buck_w.wdata = wdata_i;

    gdc_word #(
        .RST   (GDC_PROT_RST),
        .WMASK (GDC_PROT_WMASK),
        .W1C   (32'h00000000)
    ) u_prot (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .w      (prot_w.reg_side)
    );

    gdc_word #(
        .RST   (GDC_BUCK_RST),
        .WMASK (GDC_BUCK_WMASK),
        .W1C   (GDC_BUCK_W1C)
    ) u_buck (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .w      (buck_w.reg_side)
    );

    // Read mux; unmapped offsets read zero
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rdata_o  <= 32'h00000000;
            rvalid_o <= 1'b0;
        end else begin
            rvalid_o <= rd_en_i;
            if (rd_en_i) begin
                case (addr_i)
                    GDC_PROT_OFS: rdata_o <= prot_w.q;
                    GDC_BUCK_OFS: rdata_o <= buck_w.q;  // RULE11
                    default:      rdata_o <= 32'h00000000;
                endcase
            end
        end
    end

    // Trip level; registered so the comparator sees one clean level per cycle
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ocp_level_o <= GDC_PROT_RST[GDC_TRIP_LEVEL_BIT];
        end else begin
            ocp_level_o <= prot_w.q[GDC_TRIP_LEVEL_BIT];  // RULE1
        end
    end

    // Fault response; reserved codes pass through, the fault logic must treat them
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ocp_response_o <= GDC_PROT_RST[GDC_FAULT_RESP_LSB +: 2];
        end else begin
            ocp_response_o <= prot_w.q[GDC_FAULT_RESP_LSB +: 2];  // RULE2
        end
    end

    // Static sense gain code
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            sense_gain_o <= GDC_PROT_RST[GDC_GAIN_LSB +: 2];
        end else begin
            sense_gain_o <= prot_w.q[GDC_GAIN_LSB +: 2];  // RULE3
        end
    end

    // Static gain in force only while the automatic gain loop is off
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            sense_gain_use_o <= 1'b0;
        end else begin
            sense_gain_use_o <= ~auto_gain_en_i;  // RULE3
        end
    end

    // Delay compensation enable
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            dcomp_en_o <= GDC_BUCK_RST[GDC_DCOMP_EN_BIT];
        end else begin
            dcomp_en_o <= buck_w.q[GDC_DCOMP_EN_BIT];  // RULE4
        end
    end

    // Delay target code; code 0 leaves the choice to the slew-rate logic
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            target_delay_o <= GDC_BUCK_RST[GDC_TDELAY_LSB +: 4];
        end else begin
            target_delay_o <= buck_w.q[GDC_TDELAY_LSB +: 4];  // RULE5
        end
    end

    // Sequencing disable; only reset raises it again once software cleared it
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            seq_disable_o <= GDC_BUCK_RST[GDC_SEQ_DIS_BIT];
        end else begin
            seq_disable_o <= buck_w.q[GDC_SEQ_DIS_BIT];  // RULE6
        end
    end

    // Regulator current limit select
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            reg_cl_sel_o <= GDC_BUCK_RST[GDC_CL_BIT];
        end else begin
            reg_cl_sel_o <= buck_w.q[GDC_CL_BIT];  // RULE7
        end
    end

    // Regulator output voltage code
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            reg_vsel_o <= GDC_BUCK_RST[GDC_VSEL_LSB +: 2];
        end else begin
            reg_vsel_o <= buck_w.q[GDC_VSEL_LSB +: 2];  // RULE8
        end
    end

    // Regulator off; a stray write drops the supply, so software should read back
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            reg_disable_o <= GDC_BUCK_RST[GDC_DIS_BIT];
        end else begin
            reg_disable_o <= buck_w.q[GDC_DIS_BIT];  // RULE9
        end
    end

    // Low-side minimum on-time code
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            min_on_time_o <= GDC_BUCK_RST[GDC_MINON_LSB +: 3];
        end else begin
            min_on_time_o <= buck_w.q[GDC_MINON_LSB +: 3];  // RULE10
        end
    end

    // Read path: a read returns the word as stored at the read edge
    a_read_buck: assert property (@(posedge clk_i) disable iff (srst_i) // RULE11
        rd_en_i && addr_i == GDC_BUCK_OFS |=> rdata_o == $past(buck_w.q))
        else $error("second word read mismatch");
    a_buck_reserved: assert property (@(posedge clk_i) disable iff (srst_i) // RULE11
        rvalid_o && $past(addr_i) == GDC_BUCK_OFS |-> rdata_o[16:0] == 17'h00000 && !rdata_o[25])
        else $error("reserved bits read nonzero");
    a_prot_reserved: assert property (@(posedge clk_i) disable iff (srst_i) // RULE12
        rvalid_o && $past(addr_i) == GDC_PROT_OFS
            |-> (rdata_o & ~GDC_PROT_WMASK) == 32'h00000000)
        else $error("protection word reserved bits nonzero");
    a_unmapped_read: assert property (@(posedge clk_i) disable iff (srst_i) // RULE12
        rd_en_i && addr_i != GDC_PROT_OFS && addr_i != GDC_BUCK_OFS
            |=> rdata_o == 32'h00000000)
        else $error("unmapped offset read nonzero");
    a_unmapped_write: assert property (@(posedge clk_i) disable iff (srst_i) // RULE12
        wr_en_i && addr_i != GDC_PROT_OFS && addr_i != GDC_BUCK_OFS
            |=> $stable(prot_w.q) && $stable(buck_w.q))
        else $error("unmapped write changed a word");

    // Sequencing bit: a one clears it, a zero keeps it, nothing but reset sets it
    a_seq_w1c: assert property (@(posedge clk_i) disable iff (srst_i) // RULE6
        buck_w.we && wdata_i[GDC_SEQ_DIS_BIT] |=> ##1 !seq_disable_o)
        else $error("sequencing bit not cleared");
    a_seq_sticky: assert property (@(posedge clk_i) disable iff (srst_i) // RULE6
        !buck_w.q[GDC_SEQ_DIS_BIT] |=> !buck_w.q[GDC_SEQ_DIS_BIT])
        else $error("sequencing bit set by write");
    a_seq_hold: assert property (@(posedge clk_i) disable iff (srst_i) // RULE6
        buck_w.we && !wdata_i[GDC_SEQ_DIS_BIT]
            |=> buck_w.q[GDC_SEQ_DIS_BIT] == $past(buck_w.q[GDC_SEQ_DIS_BIT]))
        else $error("sequencing bit changed by written zero");

    // Decoded controls follow a write two edges later
    a_ocp_level: assert property (@(posedge clk_i) disable iff (srst_i) // RULE1
        prot_w.we |=> ##1 ocp_level_o == $past(wdata_i[GDC_TRIP_LEVEL_BIT], 2))
        else $error("trip level not taken");
    a_overcurrent_fault_response: assert property (@(posedge clk_i) disable iff (srst_i) // RULE2
        prot_w.we |=> ##1 ocp_response_o == $past(wdata_i[9:8], 2))
        else $error("fault response not taken");
    a_gain_write: assert property (@(posedge clk_i) disable iff (srst_i) // RULE3
        prot_w.we |=> ##1 sense_gain_o == $past(wdata_i[1:0], 2))
        else $error("sense gain not taken");
    a_gain_use: assert property (@(posedge clk_i) disable iff (srst_i) // RULE3
        auto_gain_en_i |=> !sense_gain_use_o) else $error("static gain used");
    // Reset holds the use flag low, so the edge that releases reset is skipped
    a_gain_static: assert property (@(posedge clk_i) disable iff (srst_i) // RULE3
        !srst_i && !auto_gain_en_i |=> sense_gain_use_o)
        else $error("static gain not in force");
    a_vsel_write: assert property (@(posedge clk_i) disable iff (srst_i) // RULE8
        buck_w.we |=> ##1 reg_vsel_o == $past(wdata_i[22:21], 2)
            && reg_disable_o == $past(wdata_i[GDC_DIS_BIT], 2)
            && reg_cl_sel_o == $past(wdata_i[GDC_CL_BIT], 2))
        else $error("regulator controls not taken");
    a_delay_write: assert property (@(posedge clk_i) disable iff (srst_i) // RULE5
        buck_w.we |=> ##1 target_delay_o == $past(wdata_i[29:26], 2)
            && dcomp_en_o == $past(wdata_i[GDC_DCOMP_EN_BIT], 2)
            && min_on_time_o == $past(wdata_i[19:17], 2))
        else $error("delay controls not taken");
    a_dcomp_en: assert property (@(posedge clk_i) disable iff (srst_i) // RULE4
        buck_w.we |=> ##1 dcomp_en_o == $past(wdata_i[GDC_DCOMP_EN_BIT], 2))
        else $error("delay compensation enable not taken");
    a_cur_limit: assert property (@(posedge clk_i) disable iff (srst_i) // RULE7
        buck_w.we |=> ##1 reg_cl_sel_o == $past(wdata_i[GDC_CL_BIT], 2))
        else $error("current limit not taken");
    a_reg_off: assert property (@(posedge clk_i) disable iff (srst_i) // RULE9
        buck_w.we |=> ##1 reg_disable_o == $past(wdata_i[GDC_DIS_BIT], 2))
        else $error("regulator disable not taken");
    a_min_on: assert property (@(posedge clk_i) disable iff (srst_i) // RULE10
        buck_w.we |=> ##1 min_on_time_o == $past(wdata_i[19:17], 2))
        else $error("minimum on-time not taken");
endmodule
`default_nettype wire

// ===== testbench/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
    import gdc_pkg::*;
    logic clk_i, srst_i, wr_en_i, rd_en_i, auto_gain_en_i;
    logic [7:0] addr_i;
    logic [31:0] wdata_i, rdata_o;
    logic rvalid_o, ocp_level_o, sense_gain_use_o, dcomp_en_o, seq_disable_o;
    logic reg_cl_sel_o, reg_disable_o;
    logic [1:0] ocp_response_o, sense_gain_o, reg_vsel_o;
    logic [3:0] target_delay_o;
    logic [2:0] min_on_time_o;
    int n_fail = 0;
    int n_compared = 0;
    gdc_regs i_dut (.clk_i(clk_i), .srst_i(srst_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .auto_gain_en_i(auto_gain_en_i),
        .rdata_o(rdata_o), .rvalid_o(rvalid_o), .ocp_level_o(ocp_level_o),
        .ocp_response_o(ocp_response_o), .sense_gain_o(sense_gain_o),
        .sense_gain_use_o(sense_gain_use_o), .dcomp_en_o(dcomp_en_o),
        .target_delay_o(target_delay_o), .seq_disable_o(seq_disable_o),
        .reg_cl_sel_o(reg_cl_sel_o), .reg_vsel_o(reg_vsel_o),
        .reg_disable_o(reg_disable_o), .min_on_time_o(min_on_time_o));
    // Decoded controls gathered so one compare covers a whole word
    wire logic [12:0] buck_q = {dcomp_en_o, target_delay_o, seq_disable_o, reg_cl_sel_o,
                                reg_vsel_o, reg_disable_o, min_on_time_o};
    wire logic [4:0]  prot_q = {ocp_level_o, ocp_response_o, sense_gain_o};
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Decoded outputs lag the write edge by one cycle
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wr_en_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_en_i <= 1'b0;
        @(posedge clk_i);
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        rd_en_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_en_i <= 1'b0;
        #1;
        chk("rvalid", {31'h0, rvalid_o}, 32'h1);
        chk("rdata", rdata_o, exp);
    endtask
    task automatic t_reset;
        chk("buck ctl", {19'h0, buck_q}, 32'h00000090);
        chk("prot ctl", {27'h0, prot_q}, 32'h00000004);
        rd(GDC_BUCK_OFS, 32'h01200000);
        rd(GDC_PROT_OFS, 32'h00000100);
    endtask
    // All ones: reserved bits stay zero and the one-clear bit drops
    task automatic t_buck;
        wr(GDC_BUCK_OFS, 32'hFFFFFFFF);
        chk("buck ctl", {19'h0, buck_q}, 32'h00001F7F);
        rd(GDC_BUCK_OFS, 32'hFCFE0000);
        wr(GDC_BUCK_OFS, 32'h00000000);
        wr(GDC_BUCK_OFS, 32'h01000000);
        chk("seq dis", {31'h0, seq_disable_o}, 32'h0);
        rd(GDC_BUCK_OFS, 32'h00000000);
    endtask
    task automatic t_prot;
        wr(GDC_PROT_OFS, 32'hFFFFFFFF);
        chk("prot ctl", {27'h0, prot_q}, 32'h0000001F);
        rd(GDC_PROT_OFS, 32'h8C0C3703);
        wr(8'h00, 32'h00000000);
        rd(8'h00, 32'h00000000);
        rd(GDC_PROT_OFS, 32'h8C0C3703);
    endtask
    // Static gain is only in force while the automatic gain is off
    task automatic t_gain;
        @(posedge clk_i);
        auto_gain_en_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        #1;
        chk("gain use", {31'h0, sense_gain_use_o}, 32'h0);
        @(posedge clk_i);
        auto_gain_en_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        chk("gain use", {31'h0, sense_gain_use_o}, 32'h1);
    endtask
    // Mid-run reset restores the sequencing bit; a written zero keeps it
    task automatic t_rst_mid;
        @(posedge clk_i);
        srst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        chk("seq dis", {31'h0, seq_disable_o}, 32'h1);
        wr(GDC_BUCK_OFS, 32'h00400000);
        chk("buck ctl", {19'h0, buck_q}, 32'h000000A0);
        rd(GDC_BUCK_OFS, 32'h01400000);
        wr(GDC_BUCK_OFS, 32'h01000000);
        chk("seq dis", {31'h0, seq_disable_o}, 32'h0);
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    initial begin
        #20000;
        n_fail++;
        print_verdict();
    end
    initial begin
        srst_i = 1'b1;
        wr_en_i = 1'b0;
        rd_en_i = 1'b0;
        auto_gain_en_i = 1'b0;
        addr_i = 8'h00;
        wdata_i = 32'h00000000;
        repeat (4) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        t_reset();
        t_buck();
        t_prot();
        t_gain();
        t_rst_mid();
        print_verdict();
    end
endmodule
`default_nettype wire
